// ---- design/clock_gating_pkg.sv ----
package clock_gating_pkg;

  // ----------------------------------------------------------------
  // peripheral identifiers
  // ----------------------------------------------------------------
  localparam int PER_N          = 32;
  localparam int ID_FAST_IRQ    = 0;
  localparam int ID_SYS_CTRL    = 1;
  localparam int ID_PORT_A      = 2;
  localparam int ID_CONVERTER   = 4;
  localparam int ID_SPI         = 5;
  localparam int ID_SERIAL0     = 6;
  localparam int ID_SERIAL1     = 7;
  localparam int ID_SYNC_SERIAL = 8;
  localparam int ID_TWO_WIRE    = 9;
  localparam int ID_PULSE_WIDTH = 10;
  localparam int ID_USB_DEV     = 11;
  localparam int ID_TIMER0      = 12;
  localparam int ID_TIMER1      = 13;
  localparam int ID_TIMER2      = 14;
  localparam int ID_EXT_EXTERNAL_INTERRUPT_0    = 30;
  localparam int ID_EXT_EXTERNAL_INTERRUPT_1    = 31;

  // bits that software may gate: 0, 2, 5..14, 30, 31
  localparam logic [PER_N-1:0] GATEABLE_MASK = 32'hc000_7fe5;
  localparam logic [PER_N-1:0] PER_EN_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // source selection and prescaler
  // ----------------------------------------------------------------
  localparam int PRES_W = 3;
  localparam int CNT_W  = 6;
  localparam int PROG_N = 3;

  localparam logic [1:0]        SRC_SLOW = 2'h0;
  localparam logic [1:0]        SRC_MAIN = 2'h1;
  localparam logic [1:0]        SRC_PLL  = 2'h2;
  localparam logic [PRES_W-1:0] PRES_MAX = 3'h6;
  localparam logic [PRES_W-1:0] PRES_RST = 3'h0;

  typedef struct packed {
    logic [1:0]        src;
    logic [PRES_W-1:0] pres;
  } clk_sel_t;

  typedef struct packed {
    logic             setStb;
    logic             clrStb;
    logic [PER_N-1:0] mask;
  } per_cmd_t;

  typedef enum logic {
    CPU_RUN  = 1'b0,
    CPU_IDLE = 1'b1
  } cpu_state_t;

endpackage : clock_gating_pkg

// ---- design/clk_gate_cell.sv ----
`timescale 1ns/100ps
module clk_gate_cell
  import clock_gating_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  // source and request
  input  wire logic srcLevel,
  input  wire logic enReq,
  // gated clock
  output logic      gatedClk,
  output logic      gateOn
);

  logic enable_r;
  logic gated_r;

  // ----------------------------------------------------------------
  // gate
  // ----------------------------------------------------------------
  // switch while low
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      enable_r <= 1'b0;
      gated_r  <= 1'b0;
    end
    else if (ce)
    begin
      if (!srcLevel)
        enable_r <= enReq;
      gated_r <= srcLevel & enable_r;
    end
  end

  assign gatedClk = gated_r;
  assign gateOn   = enable_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_gate_switch_low: assert property (@(posedge clock) disable iff (!rst_n)
    (enable_r != $past(enable_r)) |-> !$past(srcLevel))
    else $error("gate enable changed while source high");
  a_gate_off_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && !enable_r) |=> !gated_r)
    else $error("gated clock pulsed while gate off");

endmodule : clk_gate_cell

// ---- design/clk_divider.sv ----
`timescale 1ns/100ps
module clk_divider
  import clock_gating_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // source and ratio
  input  wire logic              srcLevel,
  input  wire logic [PRES_W-1:0] pres,
  // divided clock
  output logic                   divClk
);

  logic              srcPrev_r;
  logic              div_r;
  logic [CNT_W-1:0]  edgeCnt_r;
  logic [PRES_W-1:0] presEff;
  logic [CNT_W-1:0]  halfLimit;
  logic              srcRise;
  logic              atLimit;

  // ----------------------------------------------------------------
  // ratio decode: half period is 2^(pres-1) source periods
  // ----------------------------------------------------------------
  assign presEff   = (pres > PRES_MAX) ? PRES_MAX : pres;
  assign halfLimit = (presEff == PRES_RST) ? 6'h00
                   : CNT_W'((7'h01 << presEff) >> 1) - 6'h01;
  assign srcRise   = srcLevel & ~srcPrev_r;
  assign atLimit   = (edgeCnt_r >= halfLimit);

  // ----------------------------------------------------------------
  // counter and output
  // ----------------------------------------------------------------
  // programmable divide
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      srcPrev_r <= 1'b0;
      div_r     <= 1'b0;
      edgeCnt_r <= 6'h00;
    end
    else if (ce)
    begin
      srcPrev_r <= srcLevel;
      if (presEff == PRES_RST)
        div_r <= srcLevel;  // divide by one
      else if (srcRise)
      begin
        edgeCnt_r <= atLimit ? 6'h00 : edgeCnt_r + 6'h01;
        if (atLimit)
          div_r <= ~div_r;
      end
    end
  end

  assign divClk = div_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_div_toggle_limit: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && presEff != PRES_RST && srcRise && atLimit) |=> (div_r != $past(div_r)))
    else $error("divider did not toggle at limit");

endmodule : clk_divider

// ---- design/core_peripheral_clock_gating.sv ----
`timescale 1ns/100ps
// Behaviour
// - all clocks from slow, main, pll sources
// - processor, usb, per-peripheral gated clocks, ungated master clock
// - three programmable clock outputs
// - master clock source and prescaler programmable
// - processor clock stops in idle until interrupt
// - identifier is bit index of set/clear
// - fixed identifier map, reserved bits ignored
// - set/clear of system or converter ignored
// - system controller clock always running
// - converter clock auto-starts on conversion request
// - converter sleep mode stops clock after conversion
module core_peripheral_clock_gating
  import clock_gating_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // source clock pins
  input  wire logic                    slowRcClock,
  input  wire logic                    mainOscClock,
  input  wire logic                    pllOutClock,
  // clock configuration
  input  wire clk_sel_t                masterSel,
  input  wire logic [PRES_W-1:0]       usbPres,
  input  wire logic                    usbEnable,
  input  wire clk_sel_t [PROG_N-1:0]   progSel,
  input  wire logic [PROG_N-1:0]       progEnable,
  // peripheral gating commands
  input  wire per_cmd_t                perCmd,
  // processor idle and wake
  input  wire logic                    idleReq,
  input  wire logic                    wakeIrq,
  // converter activity
  input  wire logic                    convStart,
  input  wire logic                    convDone,
  input  wire logic                    convSleep,
  // generated clocks
  output logic                         processorClock,
  output logic                         masterClock,
  output logic                         usbPortClock,
  output logic [PER_N-1:0]             peripheralClock,
  output logic [PROG_N-1:0]            progClock,
  // status
  output logic [PER_N-1:0]             perClkStatus,
  output logic                         cpuIdle
);

  logic [2:0]       srcMeta_r;
  logic [2:0]       srcSync_r;
  logic [PER_N-1:0] perEnReq_r;
  logic [PER_N-1:0] perEnReq_nxt;
  logic [PER_N-1:0] perEnEff;
  logic             convClkOn_r;
  logic             convClkOn_nxt;
  cpu_state_t       cpuState_r;
  cpu_state_t       cpuState_nxt;
  logic             slowLvl;
  logic             mainLvl;
  logic             pllLvl;
  logic             masterSrcLvl;
  logic             masterLvl;
  logic             usbLvl;
  logic             cpuGateOn;

  // ----------------------------------------------------------------
  // source synchronisers
  // ----------------------------------------------------------------
  // three source clocks
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      srcMeta_r <= 3'h0;
      srcSync_r <= 3'h0;
    end
    else if (ce)
    begin
      srcMeta_r <= {pllOutClock, mainOscClock, slowRcClock};
      srcSync_r <= srcMeta_r;
    end
  end

  assign slowLvl = srcSync_r[0];
  assign mainLvl = srcSync_r[1];
  assign pllLvl  = srcSync_r[2];

  // source select for a clock selection field
  function automatic logic pickSrc(input logic [1:0] sel, input logic s, input logic m, input logic p);
    logic r;
    r = s;
    case (sel)
      SRC_SLOW: r = s;
      SRC_MAIN: r = m;
      SRC_PLL:  r = p;
      default:  r = s;
    endcase
    return r;
  endfunction : pickSrc

  // ----------------------------------------------------------------
  // master clock
  // ----------------------------------------------------------------
  // source and prescale
  assign masterSrcLvl = pickSrc(masterSel.src, slowLvl, mainLvl, pllLvl);

  clk_divider u_master_div (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .srcLevel (masterSrcLvl),
    .pres     (masterSel.pres),
    .divClk   (masterLvl)
  );

  assign masterClock = masterLvl;

  // ----------------------------------------------------------------
  // processor idle state
  // ----------------------------------------------------------------
  // idle until interrupt
  always_comb
  begin
    cpuState_nxt = cpuState_r;
    case (cpuState_r)
      CPU_RUN:  if (idleReq && !wakeIrq) cpuState_nxt = CPU_IDLE;
      CPU_IDLE: if (wakeIrq) cpuState_nxt = CPU_RUN;
      default:  cpuState_nxt = CPU_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cpuState_r <= CPU_RUN;
    else if (ce)
      cpuState_r <= cpuState_nxt;
  end

  assign cpuIdle = (cpuState_r == CPU_IDLE);

  clk_gate_cell u_cpu_gate (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .srcLevel (masterLvl),
    .enReq    (cpuState_r == CPU_RUN),
    .gatedClk (processorClock),
    .gateOn   (cpuGateOn)
  );

  // ----------------------------------------------------------------
  // usb port clock from pll
  // ----------------------------------------------------------------
  // usb clock
  clk_divider u_usb_div (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .srcLevel (pllLvl),
    .pres     (usbPres),
    .divClk   (usbLvl)
  );

  clk_gate_cell u_usb_gate (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .srcLevel (usbLvl),
    .enReq    (usbEnable),
    .gatedClk (usbPortClock),
    .gateOn   ()
  );

  // ----------------------------------------------------------------
  // peripheral enable commands
  // ----------------------------------------------------------------
  // identifier as bit index
  assign perEnReq_nxt = ((perEnReq_r & ~(perCmd.clrStb ? perCmd.mask : PER_EN_RST))
                        | (perCmd.setStb ? perCmd.mask : PER_EN_RST)) & GATEABLE_MASK;

  assign convClkOn_nxt = convStart | (convClkOn_r & ~(convDone & convSleep));

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      perEnReq_r  <= PER_EN_RST;
      convClkOn_r <= 1'b0;
    end
    else if (ce)
    begin
      perEnReq_r  <= perEnReq_nxt;
      convClkOn_r <= convClkOn_nxt;
    end
  end

  always_comb
  begin
    perEnEff               = perEnReq_r;
    perEnEff[ID_SYS_CTRL]  = 1'b1;
    perEnEff[ID_CONVERTER] = convClkOn_r;
  end

  // ----------------------------------------------------------------
  // peripheral gates
  // ----------------------------------------------------------------
  // independent peripheral clocks
  genvar gi;
  generate
    for (gi = 0; gi < PER_N; gi++)
    begin : g_per
      clk_gate_cell u_per_gate (
        .clock    (clock),
        .rst_n    (rst_n),
        .ce       (ce),
        .srcLevel (masterLvl),
        .enReq    (perEnEff[gi]),
        .gatedClk (peripheralClock[gi]),
        .gateOn   (perClkStatus[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // programmable clock outputs
  // ----------------------------------------------------------------
  // three programmable outputs
  generate
    for (gi = 0; gi < PROG_N; gi++)
    begin : g_prog
      logic progSrcLvl;
      logic progLvl;
      assign progSrcLvl = pickSrc(progSel[gi].src, slowLvl, mainLvl, pllLvl);
      clk_divider u_prog_div (
        .clock    (clock),
        .rst_n    (rst_n),
        .ce       (ce),
        .srcLevel (progSrcLvl),
        .pres     (progSel[gi].pres),
        .divClk   (progLvl)
      );
      clk_gate_cell u_prog_gate (
        .clock    (clock),
        .rst_n    (rst_n),
        .ce       (ce),
        .srcLevel (progLvl),
        .enReq    (progEnable[gi]),
        .gatedClk (progClock[gi]),
        .gateOn   ()
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // system gate must be on after any low master phase, whatever the commands did
  a_sys_ctrl_on: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && !masterLvl) |=> perClkStatus[ID_SYS_CTRL])
    else $error("system controller clock gate not on");
  // a gate still closing from an earlier conversion is left out of the antecedent
  a_cmd_ignore_conv: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && perCmd.setStb && perCmd.mask[ID_CONVERTER] && !convStart && !convClkOn_r
     && !perClkStatus[ID_CONVERTER])
    |=> !perClkStatus[ID_CONVERTER] && !convClkOn_r)
    else $error("converter clock started by set command");
  a_set_enables: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && perCmd.setStb && perCmd.mask[ID_SPI]) |=> perEnReq_r[ID_SPI])
    else $error("set command did not enable its bit");
  a_clear_disables: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && perCmd.clrStb && !perCmd.setStb && perCmd.mask[ID_TIMER0]) |=> !perEnReq_r[ID_TIMER0])
    else $error("clear command did not disable its bit");
  a_reserved_low: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 !perEnReq_r[3] && !perEnReq_r[20] && !perEnReq_r[29])
    else $error("reserved identifier became enabled");
  a_idle_wake: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && wakeIrq) |=> cpuState_r == CPU_RUN)
    else $error("interrupt did not wake processor");
  a_idle_gate_off: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && cpuIdle && !masterLvl) |=> !cpuGateOn)
    else $error("processor gate still on in idle");
  a_conv_autostart: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && convStart) |=> convClkOn_r ##0 perEnEff[ID_CONVERTER])
    else $error("converter clock not started on request");
  a_conv_sleep_stop: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && convDone && convSleep && !convStart) |=> !convClkOn_r)
    else $error("converter clock not stopped in sleep mode");

  c_idle_wake:   cover property (@(posedge clock) disable iff (!rst_n)
    cpuIdle ##[1:50] !cpuIdle);
  c_conv_sleep:  cover property (@(posedge clock) disable iff (!rst_n)
    convStart ##[1:50] (convDone && convSleep));
  c_per_enable:  cover property (@(posedge clock) disable iff (!rst_n)
    perCmd.setStb ##[1:50] peripheralClock[ID_SPI]);
  c_prog_toggle: cover property (@(posedge clock) disable iff (!rst_n)
    progClock[0] ##[1:50] !progClock[0]);

endmodule : core_peripheral_clock_gating

// ---- verification/far_side_model.sv ----
`timescale 1ns/100ps
module far_side_model
  import clock_gating_pkg::*;
#(
  parameter int CONV_CYC = 60
)
(
  // clock and conversion request
  input  wire logic clock,
  input  wire logic convReq,
  // source clocks
  output logic      slowRcClock,
  output logic      mainOscClock,
  output logic      pllOutClock,
  // converter activity
  output logic      convStart = 1'b0,
  output logic      convDone  = 1'b0
);
  logic [4:0] phase_r = 5'h00;
  int         busy_r  = 0;

  // ------------------------------------------------
  // oscillators, free running like the real parts
  // ------------------------------------------------
  // three source clocks
  always @(posedge clock) phase_r <= phase_r + 5'h01;
  assign slowRcClock  = phase_r[4]; // period 32 cycles
  assign mainOscClock = phase_r[2]; // period 8 cycles
  assign pllOutClock  = phase_r[1]; // period 4 cycles

  // ------------------------------------------------
  // converter: start pulse, done pulse after CONV_CYC
  // ------------------------------------------------
  always @(posedge clock)
  begin
    convStart <= convReq;
    convDone  <= (busy_r == 1);
    busy_r    <= convReq ? CONV_CYC : (busy_r > 0 ? busy_r - 1 : 0);
  end
endmodule : far_side_model

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
  import clock_gating_pkg::*;
();
  // clock and reset
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  ce    = 1'b1;
  // stimulus
  clk_sel_t              masterSel  = 5'h08;
  logic [PRES_W-1:0]     usbPres    = 3'h0;
  logic                  usbEnable  = 1'b0;
  clk_sel_t [PROG_N-1:0] progSel    = '0;
  logic [PROG_N-1:0]     progEnable = 3'h0;
  per_cmd_t              perCmd     = '0;
  logic                  idleReq    = 1'b0;
  logic                  wakeIrq    = 1'b0;
  logic                  convSleep  = 1'b0;
  logic                  convReq    = 1'b0;
  logic                  slowRcClock, mainOscClock, pllOutClock, convStart, convDone;
  // observed
  logic                  processorClock, masterClock, usbPortClock, cpuIdle;
  logic [PER_N-1:0]      peripheralClock, perClkStatus;
  logic [PROG_N-1:0]     progClock;
  logic [7:0]            probe;
  int                    fails = 0, nCompared = 0, halfExp = 0;
  int                    run [3] = '{0, 0, 0};
  clk_sel_t              mTab [7] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h11, 5'h13, 5'h17};
  int                    mExp [7] = '{32, 8, 4, 32, 8, 32, 256};
  int                    pExp [3] = '{32, 16, 16};

  core_peripheral_clock_gating u_core_peripheral_clock_gating (.clock(clock), .rst_n(rst_n), .ce(ce),
    .slowRcClock(slowRcClock), .mainOscClock(mainOscClock), .pllOutClock(pllOutClock),
    .masterSel(masterSel), .usbPres(usbPres), .usbEnable(usbEnable), .progSel(progSel),
    .progEnable(progEnable), .perCmd(perCmd), .idleReq(idleReq), .wakeIrq(wakeIrq),
    .convStart(convStart), .convDone(convDone), .convSleep(convSleep),
    .processorClock(processorClock), .masterClock(masterClock), .usbPortClock(usbPortClock),
    .peripheralClock(peripheralClock), .progClock(progClock), .perClkStatus(perClkStatus),
    .cpuIdle(cpuIdle));
  far_side_model u_far_side_model (.clock(clock), .convReq(convReq), .slowRcClock(slowRcClock),
    .mainOscClock(mainOscClock), .pllOutClock(pllOutClock), .convStart(convStart),
    .convDone(convDone));

  // watched clocks by index
  assign probe = {progClock, usbPortClock, peripheralClock[4], peripheralClock[5], processorClock,
                  masterClock};

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  initial
  begin
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task end_of_test;
    if (fails == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  function automatic logic expOn(input int i);
    return i == 0 || i == 2 || (i >= 5 && i <= 14) || i >= 30;
  endfunction : expOn

  task automatic cmd(input logic s, input logic c, input logic [31:0] m);
    @(posedge clock);
    perCmd <= '{setStb: s, clrStb: c, mask: m};
    @(posedge clock);
    perCmd <= '0;
  endtask : cmd

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : waitCyc

  // cycles between two rising edges and high cycles of probe[k]
  task automatic measure(input int k, output int per, output int hi);
    int  n;
    logic p;
    per = 0;
    hi  = 0;
    n   = 0;
    do begin p = probe[k]; @(negedge clock); n++; end while (!(probe[k] && !p) && n < 3000);
    do begin hi += probe[k]; per++; p = probe[k]; @(negedge clock); n++; end
    while (!(probe[k] && !p) && n < 3000);
  endtask : measure

  task automatic quiet(input int k, input int n, output logic hit);
    hit = 1'b0;
    repeat (n) begin @(negedge clock); hit |= probe[k]; end
  endtask : quiet

  // one-cycle pulse; which: 0 idle request, 1 wake interrupt, 2 conversion request
  task automatic pulse(input int which);
    @(posedge clock);
    case (which)
      0:       idleReq <= 1'b1;
      1:       wakeIrq <= 1'b1;
      default: convReq <= 1'b1;
    endcase
    @(posedge clock);
    idleReq <= 1'b0;
    wakeIrq <= 1'b0;
    convReq <= 1'b0;
  endtask : pulse

  task doReset;
    halfExp = 0;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    waitCyc(40);
    halfExp = 4;
  endtask : doReset

  // ------------------------------------------------
  // high pulse width monitor on gated clocks
  // ------------------------------------------------
  // no shortened pulse
  always @(negedge clock)
    for (int m = 0; m < 3; m++)
      if (probe[m + 1]) run[m]++;
      else
      begin
        if (run[m] != 0 && halfExp != 0) check(run[m], halfExp);
        run[m] = 0;
      end

  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    end_of_test();
  end

  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial
  begin
    int          per, hi;
    logic        hit;
    logic [31:0] expAll;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    waitCyc(40);
    check(perClkStatus, 32'h2);
    for (int t = 0; t < 7; t++)
    begin
      @(posedge clock);
      masterSel <= mTab[t];
      waitCyc(300);
      measure(0, per, hi);
      measure(0, per, hi);
      check(per, mExp[t]);
      check(hi, mExp[t] / 2);
    end
    @(posedge clock);
    masterSel <= 5'h08;
    usbEnable <= 1'b1;
    usbPres   <= 3'h2;
    progSel   <= {5'h12, 5'h09, 5'h00};
    progEnable <= 3'h7;
    waitCyc(300);
    halfExp = 4;
    measure(4, per, hi);
    measure(4, per, hi);
    check(per, 16);
    for (int k = 0; k < 3; k++)
    begin
      measure(5 + k, per, hi);
      measure(5 + k, per, hi);
      check(per, pExp[k]);
    end
    @(posedge clock);
    usbEnable  <= 1'b0;
    progEnable <= 3'h0;
    waitCyc(20);
    quiet(4, 40, hit);
    check(hit, 0);
    for (int k = 5; k < 8; k++)
    begin
      quiet(k, 40, hit);
      check(hit, 0);
    end
    for (int i = 0; i < 32; i++)
    begin
      cmd(1'b1, 1'b0, 32'h1 << i);
      waitCyc(20);
      check(perClkStatus, 32'h2 | (32'(expOn(i)) << i));
      cmd(1'b0, 1'b1, 32'h1 << i);
      waitCyc(20);
      check(perClkStatus, 32'h2);
      expAll[i] = expOn(i) | (i == 1);
    end
    // full map, set wins over clear
    cmd(1'b1, 1'b1, 32'hffff_ffff);
    waitCyc(20);
    check(perClkStatus, expAll);
    for (int j = 1; j < 13; j++)
    begin
      cmd(1'b0, 1'b1, 32'h20);
      repeat (j) @(posedge clock);
      cmd(1'b1, 1'b0, 32'h20);
      repeat (j) @(posedge clock);
    end
    measure(2, per, hi);
    check(per, 8);
    pulse(0);
    waitCyc(2);
    check(cpuIdle, 1);
    waitCyc(10);
    quiet(1, 60, hit);
    check(hit, 0);
    measure(2, per, hi);
    check(per, 8);
    pulse(1);
    waitCyc(2);
    check(cpuIdle, 0);
    measure(1, per, hi);
    check(per, 8);
    // converter starts itself, stays on outside sleep
    pulse(2);
    waitCyc(20);
    check(perClkStatus[4], 1);
    waitCyc(80);
    check(perClkStatus[4], 1);
    doReset();
    check(perClkStatus, 32'h2);
    // clock enable low: command not taken, state frozen
    halfExp = 0;
    @(posedge clock);
    ce <= 1'b0;
    cmd(1'b1, 1'b0, 32'h40);
    waitCyc(10);
    check(perClkStatus, 32'h2);
    @(posedge clock);
    ce <= 1'b1;
    waitCyc(20);
    check(perClkStatus, 32'h2);
    halfExp = 4;
    @(posedge clock);
    convSleep <= 1'b1;
    pulse(2);
    waitCyc(20);
    check(perClkStatus[4], 1);
    measure(3, per, hi);
    check(per, 8);
    cmd(1'b0, 1'b1, 32'h12);
    waitCyc(4);
    check(perClkStatus[4:1], 4'h9);
    waitCyc(80);
    check(perClkStatus[4], 0);
    end_of_test();
  end
endmodule : tb_top
